// *** hdl/ptc_defs.vh ***
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH
// ==========================================================
// register indices (byte address is four times the index)
`define PTC_IDX_CTRL0 4'h0
`define PTC_IDX_CTRL1 4'h1
`define PTC_IDX_CTRL2 4'h2
`define PTC_IDX_CNT_LO 4'h3
`define PTC_IDX_CNT_HI 4'h4
`define PTC_IDX_CMPA_LO 4'h5
`define PTC_IDX_CMPA_HI 4'h6
`define PTC_IDX_CAPB_LO 4'h7
`define PTC_IDX_CAPB_HI 4'h8
`define PTC_IDX_PER_LO 4'h9
`define PTC_IDX_PER_HI 4'hA
`define PTC_IDX_STATUS 4'hB
// ==========================================================
// control register 0 fields
`define PTC_C0_PAUSE 7
`define PTC_C0_CKSEL_HI 6
`define PTC_C0_CKSEL_LO 4
`define PTC_C0_RUN 3
// control register 1 fields
`define PTC_C1_MODE_HI 7
`define PTC_C1_MODE_LO 6
`define PTC_C1_EDGE_HI 5
`define PTC_C1_EDGE_LO 4
`define PTC_C1_CAPSRC 1
`define PTC_C1_CLRSEL 0
// control register 2 fields
`define PTC_C2_CCLR_HI 2
`define PTC_C2_CCLR_LO 1
`define PTC_C2_LATCH_EDGE 0
// status register fields (write one to clear)
`define PTC_ST_MATCH_A 0
`define PTC_ST_MATCH_P 1
// ==========================================================
// reset values and masks
`define PTC_RST_BYTE 8'h00
`define PTC_C0_WMASK 8'hF8
`define PTC_C2_WMASK 8'h06
// ==========================================================
// clock select codes
`define PTC_CK_SYS_DIV4 3'h0
`define PTC_CK_SYS 3'h1
`define PTC_CK_HI_DIV16 3'h2
`define PTC_CK_HI_DIV64 3'h3
`define PTC_CK_SUB0 3'h4
`define PTC_CK_SUB1 3'h5
`define PTC_CK_EXT_RISE 3'h6
`define PTC_CK_EXT_FALL 3'h7
// mode codes
`define PTC_MODE_CAPTURE 2'h1
`define PTC_MODE_RESERVED 2'h2
// divider ratios
`define PTC_DIV_SYS 4
`define PTC_DIV_HI_A 16
`define PTC_DIV_HI_B 64
`endif

// *** hdl/ptc_timer.v ***
`timescale 1ns/1ps
`include "ptc_defs.vh"

module ptc_timer #(
  parameter CNT_W = 16
) (
  // clock, enable and reset
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // other internal count clocks, one-cycle ticks from pclk logic
  input wire hi_clk_tick,
  input wire sub_clk_tick,
  // capture and clock inputs from outside the domain
  input wire external_clock_pin,
  input wire gate_driver_capture_input,
  input wire filter_data_out,
  input wire filter_input_select,
  // event outputs
  output reg timer_irq,
  output reg match_a_flag,
  output reg match_p_flag
);

  // ==========================================================
  // registers
  // all state below sits behind clk_en: a low enable freezes it whole,
  // including the prescalers, the synchronisers and the bus answer
  reg [7:0] ctrl0; // pause, clock select, run enable
  reg [7:0] ctrl1; // mode, edges, source, clear select
  reg [1:0] capture_clear_field; // capture clear condition
  reg latch_edge_flag; // last latching edge was rising
  reg [CNT_W-1:0] count; // main counter
  reg [CNT_W-1:0] compare_a_value; // compare A / capture A
  reg [CNT_W-1:0] capture_b_value; // capture B
  reg [CNT_W-1:0] period_value; // compare P
  reg run_d; // run enable seen last cycle
  reg [1:0] sys_div; // system clock divide by 4
  reg [5:0] hi_div; // high clock prescaler
  reg [2:0] ext_sync; // external clock synchroniser
  reg [2:0] cap_sync; // capture input synchroniser
  reg ext_prev; // agreed external clock level
  reg cap_prev; // agreed capture level

  // ==========================================================
  // decoded fields
  // field positions come from the shared definitions header
  wire run_enable = ctrl0[`PTC_C0_RUN];
  wire pause_bit = ctrl0[`PTC_C0_PAUSE];
  wire [2:0] clock_select = ctrl0[`PTC_C0_CKSEL_HI:`PTC_C0_CKSEL_LO];
  wire [1:0] mode_field = ctrl1[`PTC_C1_MODE_HI:`PTC_C1_MODE_LO];
  wire [1:0] capture_edge_field = ctrl1[`PTC_C1_EDGE_HI:`PTC_C1_EDGE_LO];
  wire capture_source_select = ctrl1[`PTC_C1_CAPSRC];
  wire clear_select = ctrl1[`PTC_C1_CLRSEL];
  // mode 10 is reserved: neither timer nor capture, so the counter
  // still steps but no clear, capture or flag is ever produced
  wire capture_mode = (mode_field == `PTC_MODE_CAPTURE);
  wire timer_mode = (mode_field != `PTC_MODE_CAPTURE) &&
                    (mode_field != `PTC_MODE_RESERVED);

  // ==========================================================
  // apb decode
  // a transfer is taken once, on the access cycle before pready rises;
  // writes land on that edge and reads are registered on it as well
  // only the low byte of the write data is used
  wire [3:0] reg_idx = paddr[5:2];
  // anything outside the twelve byte registers is refused with an error
  wire in_map = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
                (reg_idx <= `PTC_IDX_STATUS);
  wire access = psel && penable && !pready;
  wire wr_en = access && pwrite && in_map && clk_en;
  wire [7:0] wbyte = pwdata[7:0];

  // one byte read view of a register index
  // reserved and unimplemented bits read back as zero, except bits 3 and 2 of
  // control register 1, which read back as written; the counter is read a byte
  // at a time, so software must allow for a carry between the two reads
  function [7:0] read_byte;
    input [3:0] idx;
    begin
      case (idx)
        `PTC_IDX_CTRL0: read_byte = ctrl0 & `PTC_C0_WMASK;
        `PTC_IDX_CTRL1: read_byte = ctrl1;
        `PTC_IDX_CTRL2: read_byte = {5'h00, capture_clear_field, latch_edge_flag};
        `PTC_IDX_CNT_LO: read_byte = count[7:0];
        `PTC_IDX_CNT_HI: read_byte = count[15:8];
        `PTC_IDX_CMPA_LO: read_byte = compare_a_value[7:0];
        `PTC_IDX_CMPA_HI: read_byte = compare_a_value[15:8];
        `PTC_IDX_CAPB_LO: read_byte = capture_b_value[7:0];
        `PTC_IDX_CAPB_HI: read_byte = capture_b_value[15:8];
        `PTC_IDX_PER_LO: read_byte = period_value[7:0];
        `PTC_IDX_PER_HI: read_byte = period_value[15:8];
        `PTC_IDX_STATUS: read_byte = {6'h00, match_p_flag, match_a_flag};
        default: read_byte = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // synchronisers: third and second stage must agree
  // the first stage may go metastable; only the second stage reads it,
  // and a level counts once the second and third stages hold one value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync <= 3'h0;
      cap_sync <= 3'h0;
    end else if (clk_en) begin
      ext_sync <= {ext_sync[1:0], external_clock_pin};
      cap_sync <= {cap_sync[1:0], (filter_input_select ? filter_data_out :
                                   external_clock_pin)};
    end
  end

  // capture source chooses gate driver or pin/filter path
  wire cap_raw = capture_source_select ? cap_sync[2] : 1'b0;
  // the gate driver level gets its own chain so that a change of the
  // capture source need not wait for a shared chain to refill
  reg [2:0] gd_sync; // gate driver synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gd_sync <= 3'h0;
    end else if (clk_en) begin
      gd_sync <= {gd_sync[1:0], gate_driver_capture_input};
    end
  end
  wire ext_agree = (ext_sync[2] == ext_sync[1]);
  // a pulse shorter than about two clocks may never be agreed on and
  // is then lost without a capture
  wire cap_agree = capture_source_select ? (cap_sync[2] == cap_sync[1]) :
                   (gd_sync[2] == gd_sync[1]);
  wire cap_level = capture_source_select ? cap_raw : gd_sync[2];

  // edge detect on the agreed levels
  // an edge is flagged for one cycle, when the agreed level first differs
  wire ext_rise = ext_agree && ext_sync[2] && !ext_prev;
  wire ext_fall = ext_agree && !ext_sync[2] && ext_prev;
  wire cap_rise = cap_agree && cap_level && !cap_prev;
  wire cap_fall = cap_agree && !cap_level && cap_prev;

  // the agreed level is remembered only while both stages agree, so a
  // level that flickers between samples never makes a second edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
      cap_prev <= 1'b0;
    end else if (clk_en) begin
      if (ext_agree) begin
        ext_prev <= ext_sync[2];
      end
      if (cap_agree) begin
        cap_prev <= cap_level;
      end
    end
  end

  // ==========================================================
  // prescalers run only while run is enabled
  // their phase is not reset when run rises, so the first divided tick
  // after a start may come early by up to one divider period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_div <= 2'h0;
      hi_div <= 6'h00;
    end else if (clk_en) begin
      if (run_enable) begin
        sys_div <= sys_div + 2'h1;
        if (hi_clk_tick) begin
          hi_div <= hi_div + 6'h01;
        end
      end
    end
  end

  // count tick selection
  // ticks are single pclk cycles, never a second clock
  // sub clock codes 100 and 101 are the same source; the external pin
  // must not also be picked as capture input while it clocks the count
  reg tick;
  always @* begin
    case (clock_select)
      `PTC_CK_SYS_DIV4: tick = (sys_div == 2'h3);
      `PTC_CK_SYS: tick = 1'b1;
      `PTC_CK_HI_DIV16: tick = hi_clk_tick && (hi_div[3:0] == 4'hF);
      `PTC_CK_HI_DIV64: tick = hi_clk_tick && (hi_div == 6'h3F);
      `PTC_CK_SUB0: tick = sub_clk_tick;
      `PTC_CK_SUB1: tick = sub_clk_tick;
      `PTC_CK_EXT_RISE: tick = ext_rise;
      `PTC_CK_EXT_FALL: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end

  // ==========================================================
  // comparators and clear conditions
  // a comparator only acts on a counting tick, so a match that sits
  // while paused or stopped is not seen again on every clock
  wire active = run_enable && !pause_bit;
  wire step = active && tick;
  wire a_match = (count == compare_a_value);
  wire p_match = (count == period_value);
  wire at_max = (count == {CNT_W{1'b1}});
  wire p_zero = (period_value == {CNT_W{1'b0}});
  // P match with zero period means overflow clear only
  wire p_clear = step && (p_zero ? at_max : p_match);
  // a zero compare A never clears; the counter then wraps at its top
  wire a_clear = step && a_match && (compare_a_value != {CNT_W{1'b0}});
  wire tm_clear = timer_mode && (clear_select ? a_clear : p_clear);
  wire tm_a_flag = timer_mode && (clear_select ? a_clear :
                   (step && a_match && compare_a_value != {CNT_W{1'b0}}));
  wire tm_p_flag = timer_mode && !clear_select && p_clear;
  wire ovf_a_zero = timer_mode && clear_select && (compare_a_value == {CNT_W{1'b0}})
                    && step && at_max;

  // capture events, clear field selects routing
  // edge field 11 disables captures but leaves the counter running
  wire cap_en = capture_mode && run_enable;
  wire cap_to_a = cap_en && ((capture_clear_field == 2'h0) ?
                  ((capture_edge_field == 2'h0 && cap_rise) ||
                   (capture_edge_field == 2'h1 && cap_fall) ||
                   (capture_edge_field == 2'h2 && (cap_rise || cap_fall))) :
                  ((capture_edge_field == 2'h1 || capture_edge_field == 2'h2) &&
                   cap_fall));
  wire cap_to_b = cap_en && (capture_clear_field != 2'h0) &&
                  (capture_edge_field == 2'h0 || capture_edge_field == 2'h2) &&
                  cap_rise;
  wire edge_clear = cap_en && ((capture_clear_field[0] && cap_rise) ||
                    (capture_clear_field[1] && cap_fall));
  // capture mode ignores the clear select bit; only P and edges clear
  wire cp_clear = capture_mode && p_clear;

  // ==========================================================
  // counter
  // priority: a start clears first, then an automatic clear, then a step;
  // a clear on a tick replaces that step rather than following it,
  // so a period of P counts P plus one ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {CNT_W{1'b0}};
      run_d <= 1'b0;
    end else if (clk_en) begin
      run_d <= run_enable;
      if (run_enable && !run_d) begin
        count <= {CNT_W{1'b0}};
      end else if (tm_clear || cp_clear || edge_clear) begin
        count <= {CNT_W{1'b0}};
      end else if (step) begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // register writes, captures and flags
  // later assignments in this process win, which gives hardware events
  // priority over a software write or clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= `PTC_RST_BYTE;
      ctrl1 <= `PTC_RST_BYTE;
      capture_clear_field <= 2'h0;
      latch_edge_flag <= 1'b0;
      compare_a_value <= {CNT_W{1'b0}};
      capture_b_value <= {CNT_W{1'b0}};
      period_value <= {CNT_W{1'b0}};
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
      timer_irq <= 1'b0;
    end else if (clk_en) begin
      // software writes
      if (wr_en) begin
        case (reg_idx)
          `PTC_IDX_CTRL0: ctrl0 <= wbyte & `PTC_C0_WMASK;
          `PTC_IDX_CTRL1: ctrl1 <= wbyte;
          `PTC_IDX_CTRL2: capture_clear_field <= wbyte[2:1];
          `PTC_IDX_CMPA_LO: compare_a_value[7:0] <= wbyte;
          `PTC_IDX_CMPA_HI: compare_a_value[15:8] <= wbyte;
          `PTC_IDX_CAPB_LO: capture_b_value[7:0] <= wbyte;
          `PTC_IDX_CAPB_HI: capture_b_value[15:8] <= wbyte;
          `PTC_IDX_PER_LO: period_value[7:0] <= wbyte;
          `PTC_IDX_PER_HI: period_value[15:8] <= wbyte;
          // status bits clear on writing one; zero bits leave them alone
          `PTC_IDX_STATUS: begin
            if (wbyte[`PTC_ST_MATCH_A]) begin
              match_a_flag <= 1'b0;
            end
            if (wbyte[`PTC_ST_MATCH_P]) begin
              match_p_flag <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      // hardware captures win over a software write
      if (cap_to_a) begin
        compare_a_value <= count;
        latch_edge_flag <= cap_rise;
      end
      if (cap_to_b) begin
        capture_b_value <= count;
        latch_edge_flag <= 1'b1;
      end
      // flags set over a same-cycle clear
      if (tm_a_flag || cap_to_a || cap_to_b) begin
        match_a_flag <= 1'b1;
      end
      if (tm_p_flag || cp_clear) begin
        match_p_flag <= 1'b1;
      end
      // one-cycle request on compare clears and captures; a capture edge clear alone does not request
      // a wrap with compare A at zero still requests, though it sets
      // no A flag
      timer_irq <= tm_clear || cp_clear || cap_to_a || cap_to_b ||
                   ovf_a_zero;
    end
  end

  // ==========================================================
  // apb answer: ready one cycle into the access phase
  // every access takes one wait state; error stands for the single cycle
  // that pready is high while read data holds until the next access, and
  // read data is zero for writes and refused addresses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (access) begin
        pready <= 1'b1;
        pslverr <= !in_map;
        prdata <= (!pwrite && in_map) ? {24'h000000, read_byte(reg_idx)} :
                  32'h00000000;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule

// *** test/ptc_timer_sva.sv ***
`timescale 1ns/1ps
// ====
// apb and event checker
module ptc_sva (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // apb
  input logic clk_en,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // events
  input logic timer_irq,
  input logic match_a_flag,
  input logic match_p_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase taken by the slave
  sequence s_take;
    psel && penable && !pready && clk_en;
  endsequence
  // status write and bad address decode
  wire st_wr = psel && penable && !pready && clk_en && pwrite && paddr == 12'h02C;
  wire bad = paddr[11:6] != 6'h00 || paddr[5:2] > 4'hB || paddr[1:0] != 2'h0;
  a_ready_wait: assert property (s_take |=> pready)
    else $error("ready late");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_ready_cause: assert property ($rose(pready) |-> $past(psel) && $past(penable))
    else $error("ready without access");
  a_err_map: assert property (s_take |=> pslverr == bad)
    else $error("slverr wrong");
  a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("rdata upper bits set");
  a_a_sticky: assert property (match_a_flag && !(st_wr && pwdata[0]) |=> match_a_flag)
    else $error("a flag lost");
  a_p_sticky: assert property (match_p_flag && !(st_wr && pwdata[1]) |=> match_p_flag)
    else $error("p flag lost");
  a_reset_quiet: assert property ($rose(presetn) |-> !pready && !timer_irq && !match_a_flag)
    else $error("busy after reset");
endmodule
bind ptc_timer ptc_sva u_sva (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

// *** test/ptc_pin_model.sv ***
`timescale 1ns/1ps
// ====
// far-side pins: clock pin, gate driver, filter
module ptc_pins (
  // clock
  input logic pclk,
  // pins
  output logic ext_pin,
  output logic gate_in,
  output logic filt_out,
  output logic filt_sel
);
  initial begin
    ext_pin = 0;
    gate_in = 0;
    filt_out = 0;
    filt_sel = 0;
  end
  // one pulse, w cycles high then w low, wide enough to be seen once
  // g picks the pin: 0 clock pin, 1 gate driver, 2 filter output
  task pulse(input int g, input int w);
    begin
      @(posedge pclk);
      if (g == 1) gate_in <= 1; else if (g == 2) filt_out <= 1; else ext_pin <= 1;
      repeat (w) @(posedge pclk);
      if (g == 1) gate_in <= 0; else if (g == 2) filt_out <= 0; else ext_pin <= 0;
      repeat (w) @(posedge pclk);
    end
  endtask
  // filter select level, changed just after a clock edge
  task pick_filter(input bit s);
    begin
      @(posedge pclk);
      filt_sel <= s;
    end
  endtask
endmodule

// *** test/periodic_timer_capture_16bit_tb_top.sv ***
`timescale 1ns/1ps
`include "ptc_defs.vh"
`define CHK(n, x, y) begin checks_done++; if ((y) !== (x)) begin failures++; \
  $display("Error %s expected %h seen %h", n, x, y); end end
// ====
// bench top
module periodic_timer_capture_16bit_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic irq, fa, fp, ep, gi, fo, fs;
  logic ht = 1'b0, st = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] d, lo;
  logic [15:0] a0, a1;
  int failures = 0, checks_done = 0, cyc = 0, nirq = 0, n0, t0, t1;
  ptc_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hi_clk_tick(ht), .sub_clk_tick(st),
    .external_clock_pin(ep), .gate_driver_capture_input(gi), .filter_data_out(fo),
    .filter_input_select(fs), .timer_irq(irq), .match_a_flag(fa), .match_p_flag(fp));
  ptc_pins pm (.pclk(pclk), .ext_pin(ep), .gate_in(gi), .filt_out(fo), .filt_sel(fs));
  // ====
  // clock, timeout, interrupt count
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    ht <= cyc[0];
    st <= (cyc[2:0] == 3'h0);
    if (irq === 1'b1) nirq++;
    if (cyc == 90000) begin
      failures++;
      results;
    end
  end
  task results;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ====
  // apb access: setup, access, wait for ready, release, idle
  task acc(input [3:0] i, input bit w, input [7:0] v);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= {6'h00, i, 2'h0};
      pwdata <= {24'h000000, v};
      penable <= 0;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      d = prdata[7:0];
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task wr(input [3:0] i, input [7:0] v);
    acc(i, 1, v);
  endtask
  task rd(input [3:0] i, input [7:0] x);
    begin
      acc(i, 0, 8'h00);
      `CHK("register", x, d)
    end
  endtask
  task r16(input [3:0] i);
    begin
      acc(i, 0, 8'h00);
      a1[7:0] = d;
      acc(i + 4'h1, 0, 8'h00);
      a1[15:8] = d;
    end
  endtask
  // stop, change mode, restart on system clock, clear flags
  task cfg(input [7:0] c1);
    begin
      wr(`PTC_IDX_CTRL0, 8'h10);
      wr(`PTC_IDX_CTRL1, c1);
      wr(`PTC_IDX_CTRL0, 8'h18);
      wr(`PTC_IDX_STATUS, 8'h03);
    end
  endtask
  // ====
  // test sequence
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd(i[3:0], 8'h00);
    rd(`PTC_IDX_CAPB_LO, 8'h00);
    wr(`PTC_IDX_CAPB_HI, 8'hA5);
    rd(`PTC_IDX_CAPB_HI, 8'hA5);
    wr(`PTC_IDX_CTRL0, 8'hFF);
    rd(`PTC_IDX_CTRL0, 8'hF8);
    wr(`PTC_IDX_CTRL0, 8'h00);
    wr(`PTC_IDX_CTRL2, 8'hFF);
    rd(`PTC_IDX_CTRL2, 8'h06);
    wr(`PTC_IDX_CTRL2, 8'h00);
    wr(`PTC_IDX_CNT_LO, 8'h55);
    rd(`PTC_IDX_CNT_LO, 8'h00);
    acc(4'hC, 1, 8'h01);
    `CHK("slverr", 1'b1, e)
    $display("test registers done");
    wr(`PTC_IDX_PER_LO, 8'h10);
    wr(`PTC_IDX_CMPA_LO, 8'h05);
    cfg(8'h00);
    repeat (60) @(posedge pclk);
    `CHK("flags", 2'b11, {fa, fp})
    wr(`PTC_IDX_CTRL0, 8'h10);
    acc(`PTC_IDX_CNT_LO, 0, 8'h00);
    lo = d;
    `CHK("count", 1'b1, lo <= 8'h10)
    rd(`PTC_IDX_CNT_LO, lo);
    wr(`PTC_IDX_PER_LO, 8'h04);
    wr(`PTC_IDX_CMPA_LO, 8'h08);
    cfg(8'h01);
    repeat (60) @(posedge pclk);
    `CHK("flags", 2'b10, {fa, fp})
    for (int k = 6; k < 8; k++) begin
      wr(`PTC_IDX_CTRL0, 8'h00);
      wr(`PTC_IDX_CTRL0, {1'b0, k[2:0], 4'h8});
      repeat (2) pm.pulse(0, 6);
      wr(`PTC_IDX_CTRL0, {1'b1, k[2:0], 4'h8});
      repeat (2) pm.pulse(0, 6);
      wr(`PTC_IDX_CTRL0, {1'b0, k[2:0], 4'h8});
      pm.pulse(0, 6);
      rd(`PTC_IDX_CNT_LO, 8'h03);
    end
    $display("test timer done");
    wr(`PTC_IDX_PER_LO, 8'h00);
    cfg(8'h42);
    t0 = $time / 50;
    pm.pulse(0, 8);
    r16(`PTC_IDX_CMPA_LO);
    a0 = a1;
    `CHK("flag a", 1'b1, fa)
    t1 = $time / 50;
    pm.pulse(0, 8);
    r16(`PTC_IDX_CMPA_LO);
    `CHK("capture gap", 16'(t1 - t0), a1 - a0)
    wr(`PTC_IDX_CTRL2, 8'h02);
    for (int k = 0; k < 3; k++) begin
      cfg({2'h1, k[1:0], 4'h2});
      pm.pulse(0, 8);
      rd(`PTC_IDX_CTRL2, k == 0 ? 8'h03 : 8'h02);
      `CHK("flag a", 1'b1, fa)
    end
    r16(`PTC_IDX_CMPA_LO);
    `CHK("cleared capture", 1'b1, a1 <= 16'h000C)
    cfg(8'h72);
    pm.pulse(0, 8);
    `CHK("flag a", 1'b0, fa)
    cfg(8'h40);
    pm.pulse(0, 8);
    `CHK("flag a", 1'b0, fa)
    pm.pulse(1, 8);
    `CHK("flag a", 1'b1, fa)
    cfg(8'h42);
    pm.pick_filter(1'b1);
    pm.pulse(0, 8);
    `CHK("flag a", 1'b0, fa)
    pm.pulse(2, 8);
    `CHK("flag a", 1'b1, fa)
    pm.pick_filter(1'b0);
    wr(`PTC_IDX_PER_LO, 8'h20);
    cfg(8'h71);
    repeat (80) @(posedge pclk);
    `CHK("flag p", 1'b1, fp)
    $display("test capture done");
    wr(`PTC_IDX_PER_LO, 8'h00);
    wr(`PTC_IDX_CMPA_LO, 8'h00);
    wr(`PTC_IDX_CMPA_HI, 8'h00);
    cfg(8'h00);
    n0 = nirq;
    repeat (65560) @(posedge pclk);
    `CHK("irq count", 1, nirq - n0)
    `CHK("flag a", 1'b0, fa)
    $display("test wrap done");
    wr(`PTC_IDX_CTRL0, 8'h00);
    for (int c = 0; c < 6; c++) begin
      wr(`PTC_IDX_CTRL0, {1'b0, c[2:0], 4'h8});
      repeat (381) @(posedge pclk);
      wr(`PTC_IDX_CTRL0, {1'b0, c[2:0], 4'h0});
      lo = c == 0 ? 8'h60 : c == 1 ? 8'h80 : c == 2 ? 8'h0C : c == 3 ? 8'h03 : 8'h30;
      rd(`PTC_IDX_CNT_LO, lo);
    end
    $display("test prescaler done");
    results;
  end
endmodule
